/* File: rtl/bhr_pkg.sv */
// Package: constants and types for the back-up hold and reset controller
// =====================================================================
// Operation
// - Two states: clock-halt stops oscillator and CPU; wait stops CPU only.
// - Setting 0: clock-halt enters back-up only while request pin is low.
// - Setting 1: clock-halt enters back-up whatever the request pin level.
// - Clock-halt back-up ends on pin high (setting 0) or change (setting 1).
// - Wait back-up ends on any change of the request pin.
// - During back-up all display outputs and output ports are forced low.
// - Retained output pin drives high after reset.
// - Retained output pin keeps its latched value during clock-halt.
// - Supply below 1.55 V while CPU runs stops the CPU.
// - CPU restarts automatically when supply rises above 1.55 V again.
// - Low-supply stop sets a software-readable flag bit.
// - All four internal test port bits written 0 disable low-supply stop.
// - Supply rising above 1.8 V from 0 gives power-on reset to address 0.
// - Reset pin low holds reset; release starts at address 0; keep pin high.
// - Test pin high selects test mode; pulldown makes open pin normal.
// - Change on an input key-scan port pin releases clock-halt or wait.
// - Reset sets all general ports to input; frequency pin selects counter only while in reset.
// =====================================================================
package bhr_pkg;

  // =====================================================================
  // Widths and reset values
  localparam int          BHR_PC_W        = 13;
  localparam int          BHR_KEY_W       = 4;
  localparam int          BHR_TPORT_W     = 4;
  localparam int          BHR_OUT_W       = 16;
  localparam logic [12:0] BHR_RESET_PC    = 13'h0000;
  localparam logic [3:0]  BHR_TPORT_OFF   = 4'h0;
  localparam logic [3:0]  BHR_TPORT_RST   = 4'hF;
  localparam logic [3:0]  BHR_DIR_ALL_IN  = 4'h0;
  localparam logic [15:0] BHR_OUT_LOW     = 16'h0000;
  localparam logic        BHR_RET_RST     = 1'b1;
  localparam logic        BHR_MODE_LEVEL  = 1'b0;

  // =====================================================================
  // Core power states
  typedef enum logic [2:0] {
    BHR_RUN,
    BHR_HALT,
    BHR_WAIT,
    BHR_LOWV,
    BHR_RST
  } bhr_state_e;

endpackage : bhr_pkg

/* File: rtl/bhr_pin_edge.sv */
// Module: pin sampler with registered previous value and change detection
module bhr_pin_edge
  import bhr_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  // Pin and change
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out,
  output logic      [W-1:0] change_out
);

  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;
  logic         init_r;
  logic         init_nxt;

  // =====================================================================
  // Per-bit change compare, suppressed until first sample taken
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      assign change_out[g] = init_r & (prev_r[g] ^ pin_in[g]);
    end
  endgenerate
  assign level_out = pin_in;

  // Next-value logic
  always_comb begin
    prev_nxt = pin_in;
    init_nxt = 1'b1;
  end

  // Registers; reset takes constants only
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      prev_r <= '0;
      init_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      init_r <= init_nxt;
    end
  end

endmodule // bhr_pin_edge

/* File: rtl/bhr_ret_out.sv */
// Module: retained single-bit output latch
module bhr_ret_out
  import bhr_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // Core write
  input  wire logic wr_in,
  input  wire logic data_in,
  // Pin
  output logic      pin_out
);

  logic lat_r;
  logic lat_nxt;

  // Latch holds through clock-halt; no forcing here
  always_comb begin
    lat_nxt = wr_in ? data_in : lat_r;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      lat_r <= BHR_RET_RST;
    end else begin
      lat_r <= lat_nxt;
    end
  end

  assign pin_out = lat_r;

  ret_high_reset_a: assert property (@(posedge clk_in)
    !nrst_in |=> pin_out)
    else $error("retained pin not high after reset");

endmodule // bhr_ret_out

/* File: rtl/bhr_ctrl.sv */
// Module: back-up hold, low-supply stop and reset control
module bhr_ctrl
  import bhr_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   nrst_in,
  // External parties
  input  wire logic                   reset_pin_n_in,
  input  wire logic                   hold_pin_in,
  input  wire logic                   supply_ok_in,
  input  wire logic                   power_on_in,
  input  wire logic                   test_pin_in,
  // Core requests
  input  wire logic                   halt_exec_in,
  input  wire logic                   wait_exec_in,
  input  wire logic                   mode_wr_in,
  input  wire logic                   mode_in,
  input  wire logic                   tport_wr_in,
  input  wire logic [BHR_TPORT_W-1:0] tport_in,
  input  wire logic                   flag_clr_in,
  input  wire logic                   ret_wr_in,
  input  wire logic                   ret_data_in,
  input  wire logic [BHR_OUT_W-1:0]   out_data_in,
  input  wire logic [BHR_KEY_W-1:0]   key_dir_in,
  input  wire logic                   key_dir_wr_in,
  input  wire logic [BHR_KEY_W-1:0]   key_pin_in,
  input  wire logic [BHR_PC_W-1:0]    pc_next_in,
  // Status and control to core
  output logic                        cpu_run_out,
  output logic                        osc_en_out,
  output logic                        core_reset_out,
  output logic                        pc_load_out,
  output logic [BHR_PC_W-1:0]         pc_value_out,
  output logic                        lowv_flag_out,
  output logic                        test_mode_out,
  output logic                        freq_counter_sel_out,
  output logic [BHR_KEY_W-1:0]        key_dir_out,
  // Pins
  output logic [BHR_OUT_W-1:0]        port_out,
  output logic                        ret_pin_out
);

  // =====================================================================
  // Pin samplers
  logic                 hold_lvl;
  logic                 hold_chg;
  logic [BHR_KEY_W-1:0] key_lvl;
  logic [BHR_KEY_W-1:0] key_chg;

  bhr_pin_edge #(.W(1)) u_hold (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .pin_in     (hold_pin_in),
    .level_out  (hold_lvl),
    .change_out (hold_chg)
  );

  bhr_pin_edge #(.W(BHR_KEY_W)) u_key (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .pin_in     (key_pin_in),
    .level_out  (key_lvl),
    .change_out (key_chg)
  );

  // Latch returns high on pin and power-on reset too, not only nrst_in
  logic ret_nrst;
  assign ret_nrst = nrst_in && reset_pin_n_in && !power_on_in;

  bhr_ret_out u_ret (
    .clk_in  (clk_in),
    .nrst_in (ret_nrst),
    .wr_in   (ret_wr_in),
    .data_in (ret_data_in),
    .pin_out (ret_pin_out)
  );

  // =====================================================================
  // State and control registers
  bhr_state_e             state_r, state_nxt;
  logic                   mode_r, mode_nxt;
  logic [BHR_TPORT_W-1:0] tport_r, tport_nxt;
  logic                   flag_r, flag_nxt;
  logic [BHR_KEY_W-1:0]   dir_r, dir_nxt;
  logic [BHR_PC_W-1:0]    pc_r, pc_nxt;
  logic                   load_r, load_nxt;
  logic [BHR_OUT_W-1:0]   port_r, port_nxt;
  logic                   sys_reset;
  logic                   lowv_en;
  logic                   key_wake;
  logic                   halt_wake;
  logic                   backup;

  // Pin or power-on reset restarts at address 0
  assign sys_reset = !reset_pin_n_in || power_on_in;
  // Zero-written test port disables low-supply stop only when all four bits are zero
  assign lowv_en   = (tport_r != BHR_TPORT_OFF);
  // Only pins set as inputs can wake the core
  assign key_wake  = |(key_chg & ~dir_r);
  // Release condition depends on the release-setting bit
  assign halt_wake = (mode_r == BHR_MODE_LEVEL) ? hold_lvl
                                                : hold_chg;
  assign backup    = (state_r == BHR_HALT) || (state_r == BHR_WAIT);

  // Next-state logic for power state, flag and restart address
  always_comb begin
    state_nxt = state_r;
    flag_nxt  = flag_r;
    pc_nxt    = pc_r;
    load_nxt  = 1'b0;
    mode_nxt  = mode_wr_in ? mode_in : mode_r;
    tport_nxt = tport_wr_in ? tport_in : tport_r;
    dir_nxt   = key_dir_wr_in ? key_dir_in : dir_r;
    port_nxt  = out_data_in;
    if (flag_clr_in) begin
      flag_nxt = 1'b0;
    end
    case (state_r)
      BHR_RST: begin
        pc_nxt = BHR_RESET_PC;
        if (!sys_reset) begin
          state_nxt = BHR_RUN;
          load_nxt  = 1'b1;
        end
      end
      BHR_RUN: begin
        if (lowv_en && !supply_ok_in) begin
          state_nxt = BHR_LOWV;
          flag_nxt  = 1'b1;
        end else if (halt_exec_in &&
                     (mode_r != BHR_MODE_LEVEL || !hold_lvl)) begin
          state_nxt = BHR_HALT;
          pc_nxt    = pc_next_in;
        end else if (wait_exec_in) begin
          state_nxt = BHR_WAIT;
          pc_nxt    = pc_next_in;
        end
      end
      BHR_HALT: begin
        if (halt_wake || key_wake) begin
          state_nxt = BHR_RUN;
          load_nxt  = 1'b1;
        end
      end
      BHR_WAIT: begin
        if (hold_chg || key_wake) begin
          state_nxt = BHR_RUN;
          load_nxt  = 1'b1;
        end
      end
      BHR_LOWV: begin
        flag_nxt = 1'b1;                               // Set wins over clear
        if (supply_ok_in || !lowv_en) begin
          state_nxt = BHR_RUN;
        end
      end
      default: begin
        state_nxt = BHR_RST;
      end
    endcase
    if (sys_reset) begin
      state_nxt = BHR_RST;
      dir_nxt   = BHR_DIR_ALL_IN;
    end
  end

  // Register stage; reset loads output port low and test port all ones
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state_r <= BHR_RST;
      mode_r  <= BHR_MODE_LEVEL;
      tport_r <= BHR_TPORT_RST;
      flag_r  <= 1'b0;
      dir_r   <= BHR_DIR_ALL_IN;
      pc_r    <= BHR_RESET_PC;
      load_r  <= 1'b0;
      port_r  <= BHR_OUT_LOW;
    end else begin
      state_r <= state_nxt;
      mode_r  <= mode_nxt;
      tport_r <= tport_nxt;
      flag_r  <= flag_nxt;
      dir_r   <= dir_nxt;
      pc_r    <= pc_nxt;
      load_r  <= load_nxt;
      port_r  <= port_nxt;
    end
  end

  // =====================================================================
  // Outputs
  assign cpu_run_out          = (state_r == BHR_RUN);
  assign osc_en_out           = (state_r != BHR_HALT);
  assign core_reset_out       = (state_r == BHR_RST);
  assign pc_load_out          = load_r;
  assign pc_value_out         = pc_r;
  assign lowv_flag_out        = flag_r;
  assign test_mode_out        = test_pin_in;
  assign freq_counter_sel_out = core_reset_out;
  assign key_dir_out          = dir_r;
  // Forced low in back-up; retained pin is excluded on purpose
  assign port_out = backup ? BHR_OUT_LOW : port_r;

  // =====================================================================
  // Assertions
  // Entry attempt: running, halt strobe up, no reset or supply stop
  sequence s_halt_entry;
    state_r == BHR_RUN && halt_exec_in && !sys_reset &&
    !(lowv_en && !supply_ok_in);
  endsequence

  // Back-up exit: halt or wait on one edge, running on the next
  sequence s_backup_exit;
    backup ##1 cpu_run_out;
  endsequence

  halt_mode0_gate_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (s_halt_entry and (mode_r == BHR_MODE_LEVEL && hold_lvl))
    |=> state_r != BHR_HALT)
    else $error("halt entered with request pin high");

  halt_mode1_any_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    (s_halt_entry and (mode_r != BHR_MODE_LEVEL))
    |=> state_r == BHR_HALT)
    else $error("halt not entered in release setting 1");

  halt_release_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    state_r == BHR_HALT && halt_wake && !sys_reset |=> cpu_run_out ##1 1)
    else $error("halt not released");

  // Setting 0 must not leave halt while the request pin stays low and no input key pin changes
  halt_stays_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    state_r == BHR_HALT && mode_r == BHR_MODE_LEVEL && !hold_lvl &&
    !key_wake && !sys_reset |=> state_r == BHR_HALT)
    else $error("halt left while request pin low");

  wait_release_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    state_r == BHR_WAIT && hold_chg && !sys_reset |=> cpu_run_out)
    else $error("wait not released on pin change");

  key_wake_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    backup && key_wake && !sys_reset |=> cpu_run_out && pc_load_out)
    else $error("key change did not release back-up");

  backup_ports_low_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    backup |-> port_out == BHR_OUT_LOW)
    else $error("ports not low in back-up");

  halt_osc_off_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    state_r == BHR_HALT |-> !osc_en_out && !cpu_run_out)
    else $error("halt state wrong");

  wait_osc_on_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    state_r == BHR_WAIT |-> osc_en_out && !cpu_run_out)
    else $error("wait state stopped oscillator");

  // Retained pin is never forced, only written or reset
  ret_hold_halt_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    state_r == BHR_HALT && !ret_wr_in && !sys_reset
    |=> $stable(ret_pin_out))
    else $error("retained pin moved in clock halt");

  lowv_stop_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    cpu_run_out && lowv_en && !supply_ok_in && !sys_reset
    |=> !cpu_run_out && lowv_flag_out)
    else $error("low supply did not stop cpu");

  // A clear strobe during the stop must lose against the set
  flag_set_wins_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    state_r == BHR_LOWV |=> lowv_flag_out)
    else $error("low supply flag cleared during stop");

  lowv_restart_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    state_r == BHR_LOWV && supply_ok_in && !sys_reset |=> cpu_run_out)
    else $error("cpu did not restart");

  lowv_disable_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    tport_r == BHR_TPORT_OFF && cpu_run_out && !halt_exec_in &&
    !wait_exec_in && !sys_reset |=> cpu_run_out)
    else $error("disabled low supply stop still acted");

  power_on_rst_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    power_on_in |=> core_reset_out)
    else $error("power-on request did not reset");

  reset_hold_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    sys_reset |=> core_reset_out && !cpu_run_out)
    else $error("reset not held while requested");

  reset_vector_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    core_reset_out && !sys_reset |=> pc_load_out &&
    pc_value_out == BHR_RESET_PC)
    else $error("restart address not zero");

  reset_ports_in_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    sys_reset |=> key_dir_out == BHR_DIR_ALL_IN && freq_counter_sel_out)
    else $error("reset did not return ports to input");

  resume_addr_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    state_r == BHR_RUN && wait_exec_in && !halt_exec_in && lowv_en &&
    supply_ok_in && !sys_reset |=> pc_value_out == $past(pc_next_in))
    else $error("resume address not captured");

  resume_load_a: assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    s_backup_exit |-> pc_load_out && $stable(pc_value_out))
    else $error("resume load missing on back-up exit");

endmodule // bhr_ctrl

/* File: testbench/bhr_ext_model.sv */
// Partner model: reset pin, back-up request pin and supply monitor
module bhr_ext_model (
  // Clock
  input  wire logic clk_in,
  // Pins towards the controller
  output logic      reset_pin_n_out,
  output logic      hold_pin_out,
  output logic      supply_ok_out,
  output logic      power_on_out,
  output logic      test_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // =====================================================================
  // Idle levels: supply good, power-on request up until the bench drops it
  initial begin
    reset_pin_n_out = 1'b1;
    hold_pin_out    = 1'b1;
    supply_ok_out   = 1'b1;
    power_on_out    = 1'b1;
    test_pin_out    = 1'b0;
  end

  // Callers enter just after a rising edge, so pins move off the edge
  task automatic set_hold(input logic v);
    hold_pin_out = v;
  endtask
  task automatic set_supply(input logic v);
    supply_ok_out = v;
  endtask
  task automatic set_por(input logic v);
    power_on_out = v;
  endtask
  task automatic set_rst(input logic v);
    reset_pin_n_out = v;
  endtask
  task automatic set_test(input logic v);
    test_pin_out = v;
  endtask
endmodule // bhr_ext_model

/* File: testbench/bhr_ctrl_tb.sv */
// Testbench: directed scenarios for the back-up hold and reset controller
`define CHK(act, exp) begin \
  check_count++; \
  if ((act) !== (exp)) begin \
    fail_count++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, act, exp); \
  end \
end
module bhr_ctrl_tb
  import bhr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // =====================================================================
  // Signals
  logic                   clk_in, nrst_in;
  logic                   reset_pin_n_in, hold_pin_in, supply_ok_in;
  logic                   power_on_in, test_pin_in;
  logic                   halt_exec_in, wait_exec_in, mode_wr_in, mode_in;
  logic                   tport_wr_in, flag_clr_in, ret_wr_in, ret_data_in;
  logic [BHR_TPORT_W-1:0] tport_in;
  logic [BHR_OUT_W-1:0]   out_data_in, port_out;
  logic [BHR_KEY_W-1:0]   key_dir_in, key_pin_in, key_dir_out;
  logic                   key_dir_wr_in;
  logic [BHR_PC_W-1:0]    pc_next_in, pc_value_out;
  logic                   cpu_run_out, osc_en_out, core_reset_out;
  logic                   pc_load_out, lowv_flag_out, test_mode_out;
  logic                   freq_counter_sel_out, ret_pin_out;
  int                     fail_count = 0;
  int                     check_count = 0;

  bhr_ext_model ext_u (.clk_in(clk_in), .reset_pin_n_out(reset_pin_n_in),
    .hold_pin_out(hold_pin_in), .supply_ok_out(supply_ok_in),
    .power_on_out(power_on_in), .test_pin_out(test_pin_in));

  bhr_ctrl dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
    .reset_pin_n_in(reset_pin_n_in), .hold_pin_in(hold_pin_in),
    .supply_ok_in(supply_ok_in), .power_on_in(power_on_in),
    .test_pin_in(test_pin_in), .halt_exec_in(halt_exec_in),
    .wait_exec_in(wait_exec_in), .mode_wr_in(mode_wr_in), .mode_in(mode_in),
    .tport_wr_in(tport_wr_in), .tport_in(tport_in),
    .flag_clr_in(flag_clr_in), .ret_wr_in(ret_wr_in),
    .ret_data_in(ret_data_in), .out_data_in(out_data_in),
    .key_dir_in(key_dir_in), .key_dir_wr_in(key_dir_wr_in),
    .key_pin_in(key_pin_in), .pc_next_in(pc_next_in),
    .cpu_run_out(cpu_run_out), .osc_en_out(osc_en_out),
    .core_reset_out(core_reset_out), .pc_load_out(pc_load_out),
    .pc_value_out(pc_value_out), .lowv_flag_out(lowv_flag_out),
    .test_mode_out(test_mode_out),
    .freq_counter_sel_out(freq_counter_sel_out),
    .key_dir_out(key_dir_out), .port_out(port_out),
    .ret_pin_out(ret_pin_out));

  // =====================================================================
  // Clock, 40 ns period
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Step n edges, then land 1 ns after so drives never race the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Bounded wait for the run level; a stuck state shows as a mismatch
  task automatic wait_run(input logic v);
    for (int i = 0; i < 6 && cpu_run_out !== v; i++) cyc(1);
    `CHK(cpu_run_out, v)
  endtask
  task automatic pulse_halt();
    halt_exec_in = 1'b1;
    cyc(1);
    halt_exec_in = 1'b0;
  endtask
  task automatic pulse_wait();
    wait_exec_in = 1'b1;
    cyc(1);
    wait_exec_in = 1'b0;
  endtask
  task automatic set_mode(input logic v);
    mode_wr_in = 1'b1;
    mode_in = v;
    cyc(1);
    mode_wr_in = 1'b0;
  endtask
  task automatic set_tport(input logic [3:0] v);
    tport_wr_in = 1'b1;
    tport_in = v;
    cyc(1);
    tport_wr_in = 1'b0;
  endtask
  task automatic ret_write(input logic v);
    ret_wr_in = 1'b1;
    ret_data_in = v;
    cyc(1);
    ret_wr_in = 1'b0;
  endtask
  // Resume check: load strobe with the captured next address
  task automatic chk_resume(input logic [12:0] pc);
    `CHK(pc_load_out, 1'b1)
    `CHK(pc_value_out, pc)
  endtask

  // =====================================================================
  // Scenarios
  task automatic t_reset();
    cyc(8);
    `CHK(core_reset_out, 1'b1)
    `CHK(ret_pin_out, BHR_RET_RST)
    `CHK(port_out, BHR_OUT_LOW)
    `CHK(key_dir_out, BHR_DIR_ALL_IN)
    `CHK(freq_counter_sel_out, 1'b1)
    nrst_in = 1'b1;
    ext_u.set_por(1'b0);
    wait_run(1'b1);
    chk_resume(BHR_RESET_PC);
    out_data_in = 16'h5A3C;
    set_tport(BHR_TPORT_RST);
    cyc(2);
    `CHK(port_out, 16'h5A3C)
    $display("test reset done");
  endtask

  task automatic t_halt0();
    ret_write(1'b0);
    `CHK(ret_pin_out, 1'b0)
    set_mode(1'b0);
    ret_write(1'b1);
    pc_next_in = 13'h0123;
    pulse_halt();
    cyc(3);
    `CHK(cpu_run_out, 1'b1)
    ext_u.set_hold(1'b0);
    cyc(2);
    pulse_halt();
    wait_run(1'b0);
    `CHK(osc_en_out, 1'b0)
    `CHK(port_out, BHR_OUT_LOW)
    `CHK(ret_pin_out, 1'b1)
    cyc(4);
    `CHK(cpu_run_out, 1'b0)
    ext_u.set_hold(1'b1);
    wait_run(1'b1);
    chk_resume(13'h0123);
    $display("test halt setting 0 done");
  endtask

  task automatic t_halt1();
    set_mode(1'b1);
    pc_next_in = 13'h0456;
    pulse_halt();
    wait_run(1'b0);
    `CHK(osc_en_out, 1'b0)
    ext_u.set_hold(1'b0);
    wait_run(1'b1);
    chk_resume(13'h0456);
    $display("test halt setting 1 done");
  endtask

  task automatic t_wait();
    pc_next_in = 13'h1ABC;
    pulse_wait();
    wait_run(1'b0);
    `CHK(osc_en_out, 1'b1)
    `CHK(port_out, BHR_OUT_LOW)
    ext_u.set_hold(1'b1);
    wait_run(1'b1);
    chk_resume(13'h1ABC);
    key_dir_wr_in = 1'b1;
    key_dir_in = 4'h1;
    cyc(1);
    key_dir_wr_in = 1'b0;
    `CHK(key_dir_out, 4'h1)
    pulse_wait();
    wait_run(1'b0);
    key_pin_in = 4'h1;
    cyc(4);
    `CHK(cpu_run_out, 1'b0)
    key_pin_in = 4'h3;
    wait_run(1'b1);
    $display("test wait done");
  endtask

  task automatic t_lowv();
    ext_u.set_supply(1'b0);
    wait_run(1'b0);
    `CHK(lowv_flag_out, 1'b1)
    flag_clr_in = 1'b1;
    cyc(1);
    flag_clr_in = 1'b0;
    `CHK(lowv_flag_out, 1'b1)
    ext_u.set_supply(1'b1);
    wait_run(1'b1);
    `CHK(lowv_flag_out, 1'b1)
    flag_clr_in = 1'b1;
    cyc(1);
    flag_clr_in = 1'b0;
    cyc(1);
    `CHK(lowv_flag_out, 1'b0)
    set_tport(BHR_TPORT_OFF);
    ext_u.set_supply(1'b0);
    cyc(4);
    `CHK(cpu_run_out, 1'b1)
    `CHK(lowv_flag_out, 1'b0)
    ext_u.set_supply(1'b1);
    set_tport(BHR_TPORT_RST);
    $display("test low supply done");
  endtask

  task automatic t_test_pin();
    ext_u.set_test(1'b1);
    cyc(1);
    `CHK(test_mode_out, 1'b1)
    ext_u.set_test(1'b0);
    cyc(1);
    `CHK(test_mode_out, 1'b0)
    $display("test mode pin done");
  endtask

  task automatic t_pin_reset();
    ret_write(1'b0);
    `CHK(ret_pin_out, 1'b0)
    ext_u.set_rst(1'b0);
    cyc(3);
    `CHK(core_reset_out, 1'b1)
    `CHK(cpu_run_out, 1'b0)
    `CHK(key_dir_out, BHR_DIR_ALL_IN)
    `CHK(freq_counter_sel_out, 1'b1)
    `CHK(ret_pin_out, BHR_RET_RST)
    ext_u.set_rst(1'b1);
    wait_run(1'b1);
    chk_resume(BHR_RESET_PC);
    $display("test reset pin done");
  endtask

  // Supply monitor power-on request in mid-run
  task automatic t_power_on();
    ret_write(1'b0);
    ext_u.set_por(1'b1);
    cyc(2);
    `CHK(core_reset_out, 1'b1)
    `CHK(cpu_run_out, 1'b0)
    `CHK(ret_pin_out, BHR_RET_RST)
    ext_u.set_por(1'b0);
    wait_run(1'b1);
    chk_resume(BHR_RESET_PC);
    $display("test power-on done");
  endtask

  // =====================================================================
  // Verdict, reached from the sequence or the watchdog
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog, generous against a run of under a hundred cycles
  initial begin
    #200000;
    fail_count++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    final_report();
  end

  // Main sequence
  initial begin
    {nrst_in, halt_exec_in, wait_exec_in, mode_wr_in, mode_in} = '0;
    {tport_wr_in, flag_clr_in, ret_wr_in, ret_data_in, key_dir_wr_in} = '0;
    tport_in = BHR_TPORT_RST;
    key_dir_in = '0;
    key_pin_in = '0;
    pc_next_in = '0;
    out_data_in = 16'hA5C3;
    cyc(1);
    t_reset();
    t_halt0();
    t_halt1();
    t_wait();
    t_lowv();
    t_test_pin();
    t_pin_reset();
    t_power_on();
    final_report();
  end
endmodule // bhr_ctrl_tb
